// ==== rdw_pkg.sv ====
// rdw_pkg: constants shared by the receive deserializer and word aligner.
// assumes: one 100 MHz clock, apb register access, lsb-first serial data.
`default_nettype none

package rdw_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PATTERN = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;

  // control register fields
  localparam int CTRL_WIDTH10_BIT = 0; // 1: 10-bit words, 0: 8-bit
  localparam int CTRL_PAT10_BIT   = 1; // 1: 10-bit pattern, 0: 7-bit
  localparam int CTRL_COMPL_BIT   = 2; // 1: also accept complement
  localparam int CTRL_AUTO_BIT    = 3; // 1: automatic protocol mode
  localparam logic [3:0] CTRL_RESET = 4'h7;

  // status register fields
  localparam int STAT_BND_LSB     = 0; // 4-bit word boundary
  localparam int STAT_LOCKED_BIT  = 4;
  localparam int STAT_SYNC_LSB    = 5; // 2-bit sync state
  localparam int STAT_TODATA_BIT  = 7;
  localparam int STAT_FLOCK_BIT   = 8;
  localparam int STAT_PLOCK_BIT   = 9;

  // comma pattern, lsb-first, negative running disparity form
  localparam logic [9:0] COMMA_K28P5  = 10'h17C;
  localparam logic [9:0] PATTERN_RESET = 10'h17C;

  // clock recovery timing, in 10 ns cycles
  localparam int FREQ_LOCK_CYCLES  = 64;
  localparam int PHASE_LOCK_CYCLES = 32;
  localparam int RUN_LIMIT_BITS    = 20;

  // sync state machine thresholds
  localparam int SYNC_COMMAS = 3;
  localparam int LOSS_ERRORS = 4;

  typedef enum logic [0:0] {
    LOCK_REF  = 1'b0,
    LOCK_DATA = 1'b1
  } rdw_lock_e;

  typedef enum logic [1:0] {
    SYNC_LOSS = 2'h0,
    SYNC_ACQ  = 2'h1,
    SYNC_OK   = 2'h2
  } rdw_sync_e;

endpackage

`default_nettype wire

// ==== rdw_rx_align.sv ====
// rdw_rx_align: clock recovery lock select, deserializer and word aligner.
// assumes: one serial bit per mclk_i cycle on a pin, apb from the fabric,
// code_error_i and align_search_enable_i driven by logic on mclk_i.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rdw_rx_align #(
  parameter int FREQ_LOCK = rdw_pkg::FREQ_LOCK_CYCLES,
  parameter int PHASE_LOCK = rdw_pkg::PHASE_LOCK_CYCLES,
  parameter int RUN_LIMIT = rdw_pkg::RUN_LIMIT_BITS
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // serial line and lock controls
  input  wire logic        rx_serial_i,
  input  wire logic        force_ref_lock_i,
  input  wire logic        force_data_lock_i,
  output logic             lock_to_data_o,
  output logic             freq_lock_o,
  output logic             phase_lock_o,
  // fabric side
  input  wire logic        align_search_enable_i,
  input  wire logic        code_error_i,
  output logic      [9:0]  rx_data_o,
  output logic             rx_valid_o,
  output logic             align_sync_flag_o,
  output logic             align_pattern_hit_o
);

  // pattern compare, used for every candidate position
  function automatic logic pat_match(input logic [9:0] bits,
                                     input logic [9:0] pat,
                                     input logic       pat10,
                                     input logic       compl);
    logic [9:0] mask;
    logic [9:0] diff;
    mask = pat10 ? 10'h3FF : 10'h07F;
    diff = (bits ^ pat) & mask;
    pat_match = (diff == 10'h000) || (compl && (diff == mask));
  endfunction

  // ---------------- register file ----------------
  logic [3:0]  ctrl_r,   ctrl_nxt;
  logic [9:0]  pat_r,    pat_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] status_w;
  logic        mapped_w;

  assign mapped_w = (paddr_i == rdw_pkg::ADDR_CTRL) ||
                    (paddr_i == rdw_pkg::ADDR_PATTERN) ||
                    (paddr_i == rdw_pkg::ADDR_STATUS);
  // zero wait: read data is captured in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped_w;
  assign prdata_o  = prdata_r;

  // register writes and read capture
  always_comb begin
    ctrl_nxt   = ctrl_r;
    pat_nxt    = pat_r;
    prdata_nxt = prdata_r;
    if (psel_i && penable_i && pwrite_i) begin
      if (paddr_i == rdw_pkg::ADDR_CTRL)
        ctrl_nxt = pwdata_i[3:0];
      if (paddr_i == rdw_pkg::ADDR_PATTERN)
        pat_nxt = pwdata_i[9:0];
    end
    if (psel_i && !penable_i) begin
      unique case (paddr_i)
        rdw_pkg::ADDR_CTRL:    prdata_nxt = {28'h0000000, ctrl_r};
        rdw_pkg::ADDR_PATTERN: prdata_nxt = {22'h000000, pat_r};
        rdw_pkg::ADDR_STATUS:  prdata_nxt = status_w;
        default:               prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_r   <= rdw_pkg::CTRL_RESET;
      pat_r    <= rdw_pkg::PATTERN_RESET;
      prdata_r <= 32'h00000000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      pat_r    <= pat_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  logic width10_w, pat10_w, compl_w, auto_w;
  assign width10_w = ctrl_r[rdw_pkg::CTRL_WIDTH10_BIT];
  assign auto_w    = ctrl_r[rdw_pkg::CTRL_AUTO_BIT];
  // automatic mode forces the 10-bit comma, either polarity
  assign pat10_w = auto_w | ctrl_r[rdw_pkg::CTRL_PAT10_BIT];
  assign compl_w = auto_w | ctrl_r[rdw_pkg::CTRL_COMPL_BIT];

  // ---------------- serial input synchroniser ----------------
  logic ser_m_r, ser_s_r, ser_d_r;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ser_m_r <= 1'b0;
      ser_s_r <= 1'b0;
      ser_d_r <= 1'b0;
    end else begin
      ser_m_r <= rx_serial_i;
      ser_s_r <= ser_m_r;
      ser_d_r <= ser_s_r;
    end
  end

  // ---------------- clock recovery lock selection ----------------
  rdw_pkg::rdw_lock_e cru_r, cru_nxt;
  logic [15:0] fcnt_r,  fcnt_nxt;
  logic [15:0] pcnt_r,  pcnt_nxt;
  logic [15:0] run_r,   run_nxt;
  logic        flock_r, flock_nxt;
  logic        plock_r, plock_nxt;

  // run length stands in for the phase detector's loss of transitions
  always_comb begin
    cru_nxt   = cru_r;
    fcnt_nxt  = fcnt_r;
    pcnt_nxt  = pcnt_r;
    flock_nxt = flock_r;
    plock_nxt = plock_r;
    run_nxt   = (ser_s_r != ser_d_r) ? 16'h0000 : run_r + 16'h0001;
    if (force_data_lock_i)
      cru_nxt = rdw_pkg::LOCK_DATA;
    else if (force_ref_lock_i)
      cru_nxt = rdw_pkg::LOCK_REF;
    else if (cru_r == rdw_pkg::LOCK_REF && flock_r)
      cru_nxt = rdw_pkg::LOCK_DATA;
    else if (cru_r == rdw_pkg::LOCK_DATA && run_r >= 16'(RUN_LIMIT))
      cru_nxt = rdw_pkg::LOCK_REF;
    // frequency detector runs against the reference in ref mode
    if (cru_r == rdw_pkg::LOCK_REF) begin
      plock_nxt = 1'b0;
      pcnt_nxt  = 16'h0000;
      if (fcnt_r >= 16'(FREQ_LOCK))
        flock_nxt = 1'b1;
      else
        fcnt_nxt = fcnt_r + 16'h0001;
    end else begin
      fcnt_nxt  = 16'h0000;
      flock_nxt = 1'b0;
      if (run_r >= 16'(RUN_LIMIT)) begin
        pcnt_nxt  = 16'h0000;
        plock_nxt = 1'b0;
      end else if (pcnt_r >= 16'(PHASE_LOCK))
        plock_nxt = 1'b1;
      else
        pcnt_nxt = pcnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cru_r   <= rdw_pkg::LOCK_REF;
      fcnt_r  <= 16'h0000;
      pcnt_r  <= 16'h0000;
      run_r   <= 16'h0000;
      flock_r <= 1'b0;
      plock_r <= 1'b0;
    end else begin
      cru_r   <= cru_nxt;
      fcnt_r  <= fcnt_nxt;
      pcnt_r  <= pcnt_nxt;
      run_r   <= run_nxt;
      flock_r <= flock_nxt;
      plock_r <= plock_nxt;
    end
  end

  assign lock_to_data_o = (cru_r == rdw_pkg::LOCK_DATA);
  assign freq_lock_o    = flock_r;
  assign phase_lock_o   = plock_r;

  // ---------------- deserializer ----------------
  logic [19:0] sh_r,   sh_nxt;
  logic [3:0]  bcnt_r, bcnt_nxt;
  logic        word_en_w;
  logic [19:0] win_w;
  logic [3:0]  last_w;

  // new bits enter at the top, so the earliest bit ends lowest
  assign sh_nxt    = {ser_s_r, sh_r[19:1]};
  assign last_w    = width10_w ? 4'h9 : 4'h7;
  assign word_en_w = (bcnt_r == last_w);
  assign bcnt_nxt  = word_en_w ? 4'h0 : bcnt_r + 4'h1;
  // two newest words, earliest bit at index 0
  assign win_w = width10_w ? sh_nxt : {4'h0, sh_nxt[19:4]};

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sh_r   <= 20'h00000;
      bcnt_r <= 4'h0;
    end else begin
      sh_r   <= sh_nxt;
      bcnt_r <= bcnt_nxt;
    end
  end

  // ---------------- pattern detector ----------------
  logic [9:0] hit_w;
  logic [9:0] pat_sel_w;
  assign pat_sel_w = auto_w ? rdw_pkg::COMMA_K28P5 : pat_r;

  // one comparator per candidate boundary
  for (genvar p = 0; p < 10; p++) begin : g_pos
    logic fits_w;
    // a 10-bit pattern cannot start past bit 6 of an 8-bit window
    assign fits_w = width10_w ? 1'b1 :
                    ((p < 7) || (!pat10_w && p < 8));
    assign hit_w[p] = fits_w &&
        pat_match(win_w[p +: 10], pat_sel_w, pat10_w, compl_w);
  end

  logic       any_w;
  logic [3:0] first_w;
  logic       hit_bnd_w;
  logic       hit_other_w;

  // lowest position first, so the earliest received copy wins
  always_comb begin
    first_w = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (hit_w[i])
        first_w = 4'(i);
    end
  end

  // ---------------- aligner and sync machine ----------------
  rdw_pkg::rdw_sync_e sync_r, sync_nxt;
  logic [3:0] bnd_r,    bnd_nxt;
  logic       locked_r, locked_nxt;
  logic [2:0] cnt_r,    cnt_nxt;
  logic       srch_q_r;
  logic [9:0] data_r,   data_nxt;
  logic       valid_r,  sync_p_r, sync_p_nxt, phit_r, phit_nxt;

  assign any_w       = |hit_w;
  assign hit_bnd_w   = hit_w[bnd_r];
  assign hit_other_w = |(hit_w & ~(10'h001 << bnd_r));

  always_comb begin
    sync_nxt   = sync_r;
    bnd_nxt    = bnd_r;
    locked_nxt = locked_r;
    cnt_nxt    = cnt_r;
    data_nxt   = data_r;
    sync_p_nxt = 1'b0;
    phit_nxt   = 1'b0;
    // a new search request drops the held boundary
    if (!auto_w && align_search_enable_i && !srch_q_r)
      locked_nxt = 1'b0;
    if (word_en_w) begin
      if (!auto_w) begin
        sync_nxt = rdw_pkg::SYNC_LOSS;
        if (align_search_enable_i && !locked_nxt && any_w) begin
          bnd_nxt    = first_w;
          locked_nxt = 1'b1;
          sync_p_nxt = 1'b1;
          phit_nxt   = 1'b1;
        end else begin
          if (!align_search_enable_i && hit_other_w)
            sync_p_nxt = 1'b1;
          if (locked_r && hit_bnd_w)
            phit_nxt = 1'b1;
        end
      end else begin
        // search enable is not looked at here
        unique case (sync_r)
          rdw_pkg::SYNC_LOSS: if (any_w) begin
            bnd_nxt    = first_w;
            locked_nxt = 1'b1;
            cnt_nxt    = 3'h1;
            sync_nxt   = rdw_pkg::SYNC_ACQ;
            phit_nxt   = 1'b1;
          end
          rdw_pkg::SYNC_ACQ: if (code_error_i) begin
            sync_nxt   = rdw_pkg::SYNC_LOSS;
            locked_nxt = 1'b0;
          end else if (hit_bnd_w) begin
            phit_nxt = 1'b1;
            cnt_nxt  = cnt_r + 3'h1;
            if (cnt_r + 3'h1 >= 3'(rdw_pkg::SYNC_COMMAS)) begin
              sync_nxt = rdw_pkg::SYNC_OK;
              cnt_nxt  = 3'h0;
            end
          end else if (any_w) begin
            bnd_nxt  = first_w;
            cnt_nxt  = 3'h1;
            phit_nxt = 1'b1;
          end
          rdw_pkg::SYNC_OK: begin
            phit_nxt = hit_bnd_w;
            if (code_error_i) begin
              cnt_nxt = cnt_r + 3'h1;
              if (cnt_r + 3'h1 >= 3'(rdw_pkg::LOSS_ERRORS)) begin
                sync_nxt   = rdw_pkg::SYNC_LOSS;
                locked_nxt = 1'b0;
                cnt_nxt    = 3'h0;
              end
            end
          end
          default: begin
            sync_nxt   = rdw_pkg::SYNC_LOSS;
            locked_nxt = 1'b0;
          end
        endcase
      end
      // shift by the boundary chosen for this word, so a fresh hit lands low
      data_nxt = width10_w ? 10'(win_w >> bnd_nxt)
                           : {2'b00, 8'(win_w >> bnd_nxt)};
    end
  end

  // reset wipes lock and status; search resumes on release
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync_r   <= rdw_pkg::SYNC_LOSS;
      bnd_r    <= 4'h0;
      locked_r <= 1'b0;
      cnt_r    <= 3'h0;
      srch_q_r <= 1'b0;
      data_r   <= 10'h000;
      valid_r  <= 1'b0;
      sync_p_r <= 1'b0;
      phit_r   <= 1'b0;
    end else begin
      sync_r   <= sync_nxt;
      bnd_r    <= bnd_nxt;
      locked_r <= locked_nxt;
      cnt_r    <= cnt_nxt;
      srch_q_r <= align_search_enable_i;
      data_r   <= data_nxt;
      valid_r  <= word_en_w;
      sync_p_r <= sync_p_nxt;
      phit_r   <= phit_nxt;
    end
  end

  assign rx_data_o  = data_r;
  assign rx_valid_o = valid_r;
  // level in automatic mode, one-word pulse in manual mode
  assign align_sync_flag_o = auto_w ? (sync_r == rdw_pkg::SYNC_OK)
                                    : sync_p_r;
  assign align_pattern_hit_o = phit_r;

  assign status_w = {22'h000000, plock_r, flock_r, lock_to_data_o,
                     sync_r, locked_r, bnd_r};

endmodule // rdw_rx_align

`default_nettype wire

// ==== rdw_rx_align_monitor.sv ====
// rdw_rx_align_monitor: port assertions for the receive aligner.
// assumes: bound to rdw_rx_align; apb access phase lasts one cycle.
`timescale 1ns/1ps
`default_nettype none

module rdw_rx_align_monitor (
  // clock, reset and apb
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  // lock and aligner
  input wire logic        force_ref_lock_i,
  input wire logic        force_data_lock_i,
  input wire logic        lock_to_data_o,
  input wire logic        freq_lock_o,
  input wire logic        phase_lock_o,
  input wire logic        rx_valid_o,
  input wire logic        align_sync_flag_o,
  input wire logic        align_pattern_hit_o
);
  logic auto_r;
  logic auto_nxt;
  logic ctrl_wr;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // shadow of the automatic bit: the sync flag's meaning hangs on it
  assign ctrl_wr = psel_i && penable_i && pwrite_i
                   && (paddr_i == rdw_pkg::ADDR_CTRL);
  always_comb begin
    auto_nxt = ctrl_wr ? pwdata_i[rdw_pkg::CTRL_AUTO_BIT] : auto_r;
  end
  always_ff @(posedge mclk_i) begin
    auto_r <= rstn_i ? auto_nxt : 1'b0;
  end

  property p_data_forced;
    $past(rstn_i) && $past(force_data_lock_i) |-> lock_to_data_o;
  endproperty
  a_data_forced: assert property (p_data_forced)
    else $error("data lock not followed");

  property p_ref_forced;
    $past(rstn_i) && $past(force_ref_lock_i) && !$past(force_data_lock_i)
      |-> !lock_to_data_o;
  endproperty
  a_ref_forced: assert property (p_ref_forced)
    else $error("reference lock not followed");

  property p_locks_apart;
    !(freq_lock_o && phase_lock_o);
  endproperty
  a_locks_apart: assert property (p_locks_apart)
    else $error("both lock flags high");

  // reset itself is the antecedent, so no disable here
  property p_reset_clear;
    disable iff (1'b0) !rstn_i |=> !(rx_valid_o || align_sync_flag_o
      || align_pattern_hit_o || lock_to_data_o || freq_lock_o
      || phase_lock_o);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("status not cleared by reset");

  property p_hit_with_word;
    align_pattern_hit_o |-> rx_valid_o;
  endproperty
  a_hit_with_word: assert property (p_hit_with_word)
    else $error("hit without word");

  property p_manual_pulse;
    !auto_r && align_sync_flag_o |-> rx_valid_o ##1 !align_sync_flag_o;
  endproperty
  a_manual_pulse: assert property (p_manual_pulse)
    else $error("manual sync not a word pulse");

  // level may only move around a word, never between words
  property p_sync_level;
    auto_r && rx_valid_o |-> ##2 $stable(align_sync_flag_o) [*5];
  endproperty
  a_sync_level: assert property (p_sync_level)
    else $error("sync level moved between words");

  property p_word_gap;
    rx_valid_o |=> !rx_valid_o [*7];
  endproperty
  a_word_gap: assert property (p_word_gap)
    else $error("words closer than 8 cycles");

endmodule // rdw_rx_align_monitor

bind rdw_rx_align rdw_rx_align_monitor u_mon (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .force_ref_lock_i(force_ref_lock_i),
  .force_data_lock_i(force_data_lock_i),
  .lock_to_data_o(lock_to_data_o), .freq_lock_o(freq_lock_o),
  .phase_lock_o(phase_lock_o), .rx_valid_o(rx_valid_o),
  .align_sync_flag_o(align_sync_flag_o),
  .align_pattern_hit_o(align_pattern_hit_o)
);

`default_nettype wire

// ==== rdw_ser_tx.sv ====
// rdw_ser_tx: upstream serial transmitter model, one bit per clock.
// assumes: bench loads the next word at the edge where take_o is high.
`timescale 1ns/1ps
`default_nettype none

module rdw_ser_tx (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // word feed
  input  wire logic [9:0] word_i,
  input  wire logic [3:0] len_i,
  output logic            take_o,
  // serial line
  output logic            serial_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // short words shift the stream off the current boundary
  always_comb begin
    take_o  = (cnt_r + 4'h1) >= len_i;
    cnt_nxt = take_o ? 4'h0 : cnt_r + 4'h1;
  end
  always_ff @(posedge mclk_i) begin
    cnt_r <= rstn_i ? cnt_nxt : 4'h0;
  end
  // lsb leaves first, as a serializer sends it
  assign serial_o = word_i[cnt_r];

endmodule // rdw_ser_tx

`default_nettype wire

// ==== rdw_rx_align_tb_top.sv ====
// rdw_rx_align_tb_top: self-checking bench for the receive aligner.
// assumes: rdw_pkg, rdw_rx_align, monitor and serial model compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; \
  if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: %h vs %h", $time, got, exp); end end

module rdw_rx_align_tb_top;
  // bench-driven inputs
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        force_ref_lock_i = 1'b0;
  logic        force_data_lock_i = 1'b0;
  logic        align_search_enable_i = 1'b0;
  logic        code_error_i = 1'b0;
  logic [9:0]  word = 10'h2AA;
  logic [3:0]  len = 4'hA;
  // outputs and observations
  logic [31:0] prdata_o, rd;
  logic [9:0]  rx_data_o, hit_data;
  logic [2:0]  lock_last;
  logic        pready_o, pslverr_o, rx_serial_i, take, rx_valid_o, err;
  logic        lock_to_data_o, freq_lock_o, phase_lock_o;
  logic        align_sync_flag_o, align_pattern_hit_o;
  logic        sync_seen, hit_seen, sync_last;
  logic [9:0]  wq[$];
  logic [3:0]  lq[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  rdw_rx_align DUT (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_serial_i(rx_serial_i),
    .force_ref_lock_i(force_ref_lock_i),
    .force_data_lock_i(force_data_lock_i),
    .lock_to_data_o(lock_to_data_o), .freq_lock_o(freq_lock_o),
    .phase_lock_o(phase_lock_o),
    .align_search_enable_i(align_search_enable_i),
    .code_error_i(code_error_i), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .align_sync_flag_o(align_sync_flag_o),
    .align_pattern_hit_o(align_pattern_hit_o)
  );

  rdw_ser_tx u_tx (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .word_i(word), .len_i(len),
    .take_o(take), .serial_o(rx_serial_i)
  );

  always #5 mclk_i = ~mclk_i;

  // word feed and hang guard; idle filler holds no pattern at any shift
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      close_out();
    end
    if (take) begin
      word <= (wq.size() > 0) ? wq.pop_front() : 10'h2AA;
      len  <= (lq.size() > 0) ? lq.pop_front() : 4'hA;
    end
  end

  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer, then an idle edge so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic send(input logic [9:0] w, input logic [3:0] n);
    wq.push_back(w);
    lq.push_back(n);
  endtask

  // sample on falling edges, clear of the design's updates
  task automatic watch(input int n);
    sync_seen = 1'b0;
    hit_seen  = 1'b0;
    hit_data  = 10'h000;
    repeat (n) begin
      @(negedge mclk_i);
      if (align_sync_flag_o === 1'b1) sync_seen = 1'b1;
      if (align_pattern_hit_o === 1'b1 && !hit_seen) begin
        hit_seen = 1'b1;
        hit_data = rx_data_o;
      end
    end
    sync_last = align_sync_flag_o;
    lock_last = {lock_to_data_o, freq_lock_o, phase_lock_o};
    @(posedge mclk_i);
  endtask

  task automatic t_regs;
    apb(1'b0, rdw_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, rdw_pkg::CTRL_RESET)
    apb(1'b0, rdw_pkg::ADDR_PATTERN, 32'h0);
    `CHK(rd, rdw_pkg::PATTERN_RESET)
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
  endtask

  task automatic t_lock;
    force_ref_lock_i  <= 1'b1;
    force_data_lock_i <= 1'b1;
    watch(4);
    `CHK(lock_last[2], 1'b1)
    force_data_lock_i <= 1'b0;
    watch(80);
    `CHK(lock_last, 3'b010)
    force_ref_lock_i <= 1'b0;
    watch(110);
    `CHK(lock_last, 3'b101)
    repeat (3) send(10'h000, 4'hA);
    watch(45);
    `CHK(lock_last[2], 1'b0)
  endtask

  task automatic t_manual;
    align_search_enable_i <= 1'b1;
    send(10'h2AA, 4'h3);
    send(rdw_pkg::COMMA_K28P5, 4'hA);
    watch(60);
    `CHK(sync_seen, 1'b1)
    `CHK(hit_data, rdw_pkg::COMMA_K28P5)
    send(~rdw_pkg::COMMA_K28P5, 4'hA);
    watch(40);
    `CHK(sync_seen, 1'b0)
    `CHK(hit_data, ~rdw_pkg::COMMA_K28P5)
    apb(1'b1, rdw_pkg::ADDR_CTRL, 32'h3);
    send(~rdw_pkg::COMMA_K28P5, 4'hA);
    watch(40);
    `CHK(hit_seen, 1'b0)
  endtask

  task automatic t_resync;
    align_search_enable_i <= 1'b0;
    send(10'h2AA, 4'h4);
    repeat (2) send(rdw_pkg::COMMA_K28P5, 4'hA);
    watch(50);
    `CHK(sync_seen, 1'b1)
    `CHK(hit_seen, 1'b0)
  endtask

  // two 7-bit matches seven bits apart: the earlier must win
  task automatic t_seven;
    apb(1'b1, rdw_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, rdw_pkg::ADDR_PATTERN, 32'h7C);
    align_search_enable_i <= 1'b1;
    send(10'h2AA, 4'h2);
    send(10'h27C, 4'hA);
    send(10'h2AF, 4'hA);
    watch(60);
    `CHK(hit_data, 10'h27C)
  endtask

  // 8-bit words, 7-bit exact pattern, fresh search
  task automatic t_byte;
    apb(1'b1, rdw_pkg::ADDR_CTRL, 32'h0);
    align_search_enable_i <= 1'b0;
    watch(1);
    align_search_enable_i <= 1'b1;
    send(10'h07C, 4'h8);
    watch(60);
    `CHK(hit_data, 10'h07C)
  endtask

  task automatic t_auto;
    apb(1'b1, rdw_pkg::ADDR_CTRL, 32'h9);
    align_search_enable_i <= 1'b0;
    send(10'h2AA, 4'h5);
    repeat (3) send(rdw_pkg::COMMA_K28P5, 4'hA);
    watch(70);
    `CHK(hit_data, rdw_pkg::COMMA_K28P5)
    `CHK(sync_last, 1'b1)
    apb(1'b0, rdw_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[rdw_pkg::STAT_SYNC_LSB +: 2], rdw_pkg::SYNC_OK)
    `CHK(rd[rdw_pkg::STAT_LOCKED_BIT], 1'b1)
    code_error_i <= 1'b1;
    watch(50);
    `CHK(sync_last, 1'b0)
    code_error_i <= 1'b0;
  endtask

  task automatic t_reset;
    rstn_i <= 1'b0;
    watch(3);
    `CHK({lock_last, sync_last}, 4'h0)
    rstn_i <= 1'b1;
    watch(2);
    apb(1'b0, rdw_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, rdw_pkg::CTRL_RESET)
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_lock();
    t_manual();
    t_resync();
    t_seven();
    t_byte();
    t_auto();
    t_reset();
    close_out();
  end

endmodule // rdw_rx_align_tb_top

`default_nettype wire
